// *** rtl/sffe_device.sv ***
// Device end of the serial flash front end and its receive FIFO
`timescale 1ns/1ns

module sffe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   wire              doWr = inValid & inReady;
   wire              doRd = outValid & outReady;

   // Extra pointer bit tells full from empty; depth must be a power of two
   assign inReady  = (wrPtr_r ^ rdPtr_r) != {1'b1, {AW{1'b0}}};
   assign outValid = wrPtr_r != rdPtr_r;
   assign outData  = mem[rdPtr_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         wrPtr_r <= doWr ? wrPtr_r + 1'b1 : wrPtr_r;
         rdPtr_r <= doRd ? rdPtr_r + 1'b1 : rdPtr_r;
      end
   end

   always_ff @(posedge clk) begin
      if (doWr) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end
endmodule

module sffe_device (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Link
   sffe_link_if.dev        link,
   // Configuration
   input  wire logic       quadLaneEnableBit,
   input  wire logic       pinSelBit,
   input  wire logic       srProtectBit,
   // Received bytes
   output logic            rxValid,
   input  wire logic       rxReady,
   output logic [7:0]      rxData,
   // Read data source
   input  wire logic [7:0] txData,
   input  wire logic       txValid,
   output logic            txReady,
   // Status
   output logic [7:0]      cmdCode,
   output logic            cmdValid,
   output logic            statusWriteBlock,
   output logic            busy,
   output logic            paused,
   output logic            rxOverrun
);
   typedef enum {ST_OPC, ST_ADDR, ST_DIN, ST_DOUT, ST_SKIP} sffe_dstate_t;

   logic [5:0]   syncA_r;
   logic [5:0]   syncB_r;
   logic         sclkPrev_r;
   logic         csPrev_r;
   logic         active_r;
   logic         paused_r;
   sffe_dstate_t st_r;
   logic [2:0]   bitCnt_r;
   logic [7:0]   shift_r;
   logic [1:0]   byteCnt_r;
   logic [7:0]   op_r;
   logic [7:0]   txSh_r;
   logic         outOn_r;
   logic         rstArm_r;
   logic [11:0]  swCnt_r;
   logic [6:0]   hwCnt_r;
   logic [3:0]   devOut_r;
   logic [3:0]   devOeN_r;
   logic         cmdValid_r;
   logic [7:0]   cmdCode_r;
   logic         txReady_r;
   logic         wpBlock_r;
   logic         busy_r;
   logic         overrun_r;
   logic         push_r;
   logic [7:0]   pushData_r;
   logic         fifoInReady;

   wire          qe          = quadLaneEnableBit;
   wire          sclkS       = syncB_r[0];
   wire          csS         = syncB_r[1];
   wire [3:0]    laneS       = syncB_r[5:2];
   wire          serialInPin = laneS[0];
   // Only edges inside a frame matter, so idle level of mode 0 or 3 is irrelevant
   wire          sclkRise    = sclkS & ~sclkPrev_r; // R5
   wire          sclkFall    = ~sclkS & sclkPrev_r; // R5
   wire          csFall      = csPrev_r & ~csS;
   wire          holdFn      = ~qe & ~pinSelBit; // R8 R14 R15
   wire          rstFn       = ~qe & pinSelBit; // R8 R15 R17
   wire          pauseIn     = holdFn & ~csS & ~laneS[3]; // R10
   wire          hwRst       = rstFn & (hwCnt_r == sffe_pkg::RST_PIN_CYC); // R17
   wire          swBusy      = swCnt_r != 12'h000;
   wire          go          = active_r & ~csS & ~paused_r; // R12
   wire [2:0]    inW         = (st_r == ST_ADDR) ? sffe_pkg::addrLanes(op_r) : 3'd1;
   wire [2:0]    outW        = sffe_pkg::dataLanes(op_r, qe);
   wire [2:0]    curW        = (st_r == ST_DOUT) ? outW : inW;
   wire [3:0]    bitSum      = {1'b0, bitCnt_r} + {1'b0, curW};
   wire          byteEnd     = bitSum[3];
   wire [7:0]    shIn        = (inW == 3'd4) ? {shift_r[3:0], laneS} :
                               (inW == 3'd2) ? {shift_r[5:0], laneS[1:0]} :
                               {shift_r[6:0], serialInPin};
   wire          opEnd       = go & sclkRise & (st_r == ST_OPC) & byteEnd;
   wire          swStart     = opEnd & (shIn == sffe_pkg::OP_RESET) & rstArm_r; // R18
   wire [7:0]    txNext      = txValid ? txData : 8'hff;
   wire [7:0]    txShifted   = txSh_r << curW;
   wire [3:0]    outBits     = (outW == 3'd4) ? txSh_r[7:4] :
                               (outW == 3'd2) ? {2'b00, txSh_r[7:6]} : {2'b00, txSh_r[7], 1'b0};
   wire [3:0]    oeMask      = (outW == 3'd4) ? 4'h0 : (outW == 3'd2) ? 4'hc : 4'hd;
   sffe_dstate_t opNext;

   // Unhonoured quad reads and the reset opcode swallow the rest of the frame
   assign opNext = (sffe_pkg::dataLanes(shIn, qe) == 3'd0) ? ST_SKIP : // R7
                   sffe_pkg::isRead(shIn) ? ST_ADDR :
                   (shIn == sffe_pkg::OP_RESET) ? ST_SKIP : ST_DIN;

   assign link.devOut      = devOut_r;
   assign link.devOeN      = devOeN_r;
   assign txReady          = txReady_r;
   assign cmdCode          = cmdCode_r;
   assign cmdValid         = cmdValid_r;
   assign statusWriteBlock = wpBlock_r;
   assign busy             = busy_r;
   assign paused           = paused_r;
   assign rxOverrun        = overrun_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         syncA_r    <= sffe_pkg::SYNC_RST;
         syncB_r    <= sffe_pkg::SYNC_RST;
         sclkPrev_r <= 1'b0;
         csPrev_r   <= 1'b1;
      end else begin
         syncA_r    <= {link.lane, link.csN, link.sclk};
         syncB_r    <= syncA_r;
         sclkPrev_r <= sclkS;
         csPrev_r   <= csS;
      end
   end

   // Frame starts only on a seen chip select fall, never at reset release
   always_ff @(posedge clk) begin
      if (!rst_n || hwRst || swStart) begin
         active_r <= 1'b0; // R2
      end else if (csFall) begin
         active_r <= ~swBusy; // R2 R18
      end else if (csS) begin
         active_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || csS || hwRst) begin
         paused_r <= 1'b0;
      end else if (!paused_r && pauseIn && !sclkS) begin
         paused_r <= 1'b1; // R10
      end else if (paused_r && !pauseIn && !sclkS) begin
         paused_r <= 1'b0; // R11
      end
   end

   always_ff @(posedge clk) begin
      push_r     <= 1'b0;
      cmdValid_r <= 1'b0;
      txReady_r  <= 1'b0;
      if (!rst_n || hwRst || !active_r || csS) begin
         st_r       <= ST_OPC; // R13
         bitCnt_r   <= 3'd0;
         byteCnt_r  <= 2'd0;
         outOn_r    <= 1'b0;
         devOut_r   <= 4'h0;
         shift_r    <= 8'h00;
         txSh_r     <= 8'hff;
         pushData_r <= 8'h00;
         if (!rst_n) begin
            op_r      <= 8'h00;
            cmdCode_r <= 8'h00;
         end
      end else if (go && sclkRise && st_r != ST_DOUT && st_r != ST_SKIP) begin
         shift_r  <= shIn; // R3
         bitCnt_r <= bitSum[2:0];
         if (byteEnd) begin
            case (st_r)
               ST_OPC: begin
                  op_r       <= shIn; // R19
                  cmdCode_r  <= shIn;
                  cmdValid_r <= 1'b1;
                  st_r       <= opNext;
               end
               ST_ADDR: begin
                  push_r     <= 1'b1;
                  pushData_r <= shIn;
                  byteCnt_r  <= byteCnt_r + 2'd1;
                  if (byteCnt_r == 2'(sffe_pkg::ADDR_BYTES - 1)) begin
                     st_r      <= ST_DOUT;
                     txSh_r    <= txNext;
                     txReady_r <= txValid;
                  end
               end
               default: begin
                  push_r     <= 1'b1;
                  pushData_r <= shIn;
               end
            endcase
         end
      end else if (go && sclkFall && st_r == ST_DOUT) begin
         devOut_r  <= outBits; // R4 R6 R7
         outOn_r   <= 1'b1;
         bitCnt_r  <= bitSum[2:0];
         txSh_r    <= byteEnd ? txNext : txShifted;
         txReady_r <= byteEnd & txValid;
      end
   end

   // Lanes released while deselected, paused or before the first output fall
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         devOeN_r <= 4'hf;
      end else begin
         devOeN_r <= (go && st_r == ST_DOUT && outOn_r) ? oeMask : 4'hf; // R1 R12
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || hwRst || swStart) begin
         rstArm_r <= 1'b0;
      end else if (opEnd) begin
         rstArm_r <= shIn == sffe_pkg::OP_RST_EN; // R18
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         swCnt_r <= 12'h000;
         hwCnt_r <= 7'h00;
      end else begin
         swCnt_r <= swStart ? sffe_pkg::SW_RST_CYC : (swBusy ? swCnt_r - 12'h001 : swCnt_r); // R18
         hwCnt_r <= (!rstFn || laneS[3]) ? 7'h00 : (hwRst ? hwCnt_r : hwCnt_r + 7'h01); // R17
      end
   end

   // No way to stall the link, so a full FIFO loses the byte and flags it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wpBlock_r <= 1'b0;
         busy_r    <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         wpBlock_r <= ~qe & ~laneS[2] & srProtectBit; // R9
         busy_r    <= swBusy | hwRst;
         overrun_r <= (push_r & ~fifoInReady) | (overrun_r & ~csFall);
      end
   end

   sffe_fifo #(
      .WIDTH (sffe_pkg::FIFO_WIDTH),
      .DEPTH (sffe_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (push_r),
      .inReady  (fifoInReady),
      .inData   (pushData_r),
      .outValid (rxValid),
      .outReady (rxReady),
      .outData  (rxData)
   );
endmodule

// *** rtl/sffe_host.sv ***
// Host end of the serial flash front end: makes the clock and runs frames
`timescale 1ns/1ns

module sffe_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Link
   sffe_link_if.host        link,
   // Pin control
   input  wire logic        quadLaneEnableBit,
   input  wire logic        wpLevel,
   input  wire logic        holdReq,
   // Command
   input  wire logic        cmdValid,
   output logic             cmdReady,
   input  wire logic [7:0]  cmdOpcode,
   input  wire logic [23:0] cmdAddr,
   input  wire logic [7:0]  cmdLen,
   // Write data
   input  wire logic [7:0]  wrData,
   input  wire logic        wrValid,
   output logic             wrReady,
   // Read data
   output logic [7:0]       rdData,
   output logic             rdValid,
   output logic             busy
);
   typedef enum {H_IDLE, H_SEL, H_RUN, H_END, H_GAP} sffe_hstate_t;

   sffe_hstate_t st_r;
   logic [3:0]   syncA_r;
   logic [3:0]   syncB_r;
   logic [3:0]   div_r;
   logic         sclk_r;
   logic         csN_r;
   logic [7:0]   op_r;
   logic [23:0]  addr_r;
   logic [7:0]   len_r;
   logic [8:0]   idx_r;
   logic [2:0]   bitCnt_r;
   logic [7:0]   txSh_r;
   logic [7:0]   rxSh_r;
   logic [3:0]   out_r;
   logic [3:0]   oeN_r;
   logic         cmdReady_r;
   logic         wrReady_r;
   logic [7:0]   rdData_r;
   logic         rdValid_r;
   logic         busy_r;
   logic         rstArm_r;
   logic [11:0]  wait_r;

   function automatic logic [2:0] widthOf(input logic [7:0] op, input logic qe, input logic [8:0] i);
      logic [2:0] w;
      w = sffe_pkg::dataLanes(op, qe);
      if (i == 9'd0 || !sffe_pkg::isRead(op)) begin
         return 3'd1;
      end else if (i <= 9'(sffe_pkg::ADDR_BYTES)) begin
         return sffe_pkg::addrLanes(op);
      end
      return (w == 3'd0) ? 3'd1 : w;
   endfunction

   wire       qe      = quadLaneEnableBit;
   wire       isRd    = sffe_pkg::isRead(op_r);
   wire       tick    = div_r == sffe_pkg::HOST_HALF_CYC - 4'h1;
   // Clock frozen low during a pause, chip select stays low meanwhile
   wire       frz     = holdReq & ~qe & ~sclk_r & (st_r == H_RUN); // R13
   wire [8:0] total   = 9'd1 + (isRd ? 9'(sffe_pkg::ADDR_BYTES) : 9'd0) + {1'b0, len_r};
   wire [8:0] nextIdx = idx_r + 9'd1;
   wire       newByte = bitCnt_r == 3'd0;
   wire [2:0] curW    = widthOf(op_r, qe, idx_r);
   wire       curRd   = isRd & (idx_r > 9'(sffe_pkg::ADDR_BYTES));
   wire [3:0] bitSum  = {1'b0, bitCnt_r} + {1'b0, curW};
   wire       needWr  = newByte & ~isRd & (nextIdx < total);
   wire       stall   = needWr & ~wrValid;
   wire [7:0] srcByte = (nextIdx == 9'd1) ? (isRd ? addr_r[23:16] : wrData) :
                        (nextIdx == 9'd2) ? (isRd ? addr_r[15:8] : wrData) :
                        (nextIdx == 9'd3) ? (isRd ? addr_r[7:0] : wrData) : wrData;
   wire [7:0] preB    = newByte ? srcByte : txSh_r;
   wire [2:0] preW    = newByte ? widthOf(op_r, qe, nextIdx) : curW;
   wire       preRd   = newByte ? (isRd & (nextIdx > 9'(sffe_pkg::ADDR_BYTES))) : curRd;
   wire [3:0] preOut  = (preW == 3'd4) ? preB[7:4] : (preW == 3'd2) ? {2'b00, preB[7:6]} : {3'b000, preB[7]};
   wire [3:0] preOeN  = preRd ? 4'hf : (preW == 3'd4) ? 4'h0 : (preW == 3'd2) ? 4'hc : 4'he;
   wire [7:0] rxIn    = (curW == 3'd4) ? {rxSh_r[3:0], syncB_r} :
                        (curW == 3'd2) ? {rxSh_r[5:0], syncB_r[1:0]} : {rxSh_r[6:0], syncB_r[1]};

   assign link.sclk    = sclk_r;
   assign link.csN     = csN_r;
   assign link.hostOut = out_r;
   assign link.hostOeN = oeN_r;
   assign cmdReady     = cmdReady_r;
   assign wrReady      = wrReady_r;
   assign rdData       = rdData_r;
   assign rdValid      = rdValid_r;
   assign busy         = busy_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         syncA_r <= 4'hf;
         syncB_r <= 4'hf;
      end else begin
         syncA_r <= link.lane;
         syncB_r <= syncA_r;
      end
   end

   // Divider keeps the link clock far below its ceiling
   always_ff @(posedge clk) begin
      cmdReady_r <= 1'b0;
      wrReady_r  <= 1'b0;
      rdValid_r  <= 1'b0;
      if (!rst_n) begin
         st_r     <= H_IDLE;
         div_r    <= 4'h0;
         sclk_r   <= 1'b0; // R5 R16
         csN_r    <= 1'b1; // R2
         op_r     <= 8'h00;
         addr_r   <= 24'h000000;
         len_r    <= 8'h00;
         idx_r    <= 9'd0;
         bitCnt_r <= 3'd0;
         txSh_r   <= 8'h00;
         rxSh_r   <= 8'h00;
         out_r    <= 4'h0;
         oeN_r    <= 4'hf;
         rdData_r <= 8'h00;
         busy_r   <= 1'b0;
         rstArm_r <= 1'b0;
         wait_r   <= 12'h000;
      end else begin
         div_r  <= (tick || frz || st_r == H_IDLE) ? 4'h0 : div_r + 4'h1;
         busy_r <= st_r != H_IDLE;
         case (st_r)
            H_IDLE: begin
               if (cmdValid) begin
                  cmdReady_r <= 1'b1;
                  op_r       <= cmdOpcode;
                  addr_r     <= cmdAddr;
                  len_r      <= cmdLen;
                  csN_r      <= 1'b0;
                  idx_r      <= 9'd0;
                  bitCnt_r   <= 3'd0;
                  out_r      <= {3'b000, cmdOpcode[7]}; // R19
                  oeN_r      <= 4'he;
                  txSh_r     <= {cmdOpcode[6:0], 1'b0};
                  st_r       <= H_SEL;
               end
            end
            H_SEL: begin
               st_r <= tick ? H_RUN : H_SEL;
            end
            H_RUN: begin
               if (tick && !frz) begin
                  if (!sclk_r) begin
                     sclk_r   <= 1'b1;
                     bitCnt_r <= bitSum[2:0];
                     rxSh_r   <= rxIn;
                     if (bitSum[3] && curRd) begin
                        rdData_r  <= rxIn;
                        rdValid_r <= 1'b1;
                     end
                  end else if (newByte && nextIdx == total) begin
                     sclk_r <= 1'b0;
                     oeN_r  <= 4'hf;
                     st_r   <= H_END;
                  end else if (!stall) begin
                     sclk_r    <= 1'b0;
                     out_r     <= preOut; // R6 R7
                     oeN_r     <= preOeN;
                     txSh_r    <= preB << preW;
                     idx_r     <= newByte ? nextIdx : idx_r;
                     wrReady_r <= needWr;
                  end
               end
            end
            H_END: begin
               if (tick) begin
                  csN_r    <= 1'b1;
                  rstArm_r <= op_r == sffe_pkg::OP_RST_EN;
                  wait_r   <= (op_r == sffe_pkg::OP_RESET && rstArm_r) ? sffe_pkg::SW_RST_CYC : // R18
                              12'(sffe_pkg::HOST_HALF_CYC);
                  st_r     <= H_GAP;
               end
            end
            H_GAP: begin
               wait_r <= wait_r - 12'h001;
               st_r   <= (wait_r == 12'h000) ? H_IDLE : H_GAP;
            end
            default: begin
               st_r <= H_IDLE;
            end
         endcase
         // Without quad enable lanes 2 and 3 carry protect and pause
         if (!qe) begin
            out_r[3:2] <= {~holdReq, wpLevel}; // R8 R9 R10 R11
            oeN_r[3:2] <= 2'b00;
         end
      end
   end
endmodule

// *** rtl/sffe_link_if.sv ***
// Link wires between the flash front end and its host controller
`timescale 1ns/1ns
interface sffe_link_if;
   logic       sclk;
   logic       csN;
   logic [3:0] hostOut;
   logic [3:0] hostOeN;
   logic [3:0] devOut;
   logic [3:0] devOeN;
   logic [3:0] lane;

   // Undriven lanes float high through pull-ups
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lane[i] = !devOeN[i] ? devOut[i] : (!hostOeN[i] ? hostOut[i] : 1'b1);
      end
   end

   modport dev (input sclk, input csN, input lane, output devOut, output devOeN);
   modport host (output sclk, output csN, output hostOut, output hostOeN, input lane);
endinterface

// *** rtl/sffe_pkg.sv ***
// Shared constants, opcodes and lane decoding for the serial flash front end
// Notes on behaviour
// R1: Chip select high tri-states every output lane
// R2: Instructions refused until chip select falls once
// R3: Single lane input sampled on clock rise
// R4: Single lane output changes on clock fall
// R5: Only clock modes 0 and 3 supported
// R6: Dual reads turn lanes 0,1 bidirectional
// R7: Quad reads use four lanes, need quad enable
// R8: Quad enable turns protect/pause pins into lanes
// R9: Active-low protect pin blocks status writes
// R10: Pause starts at pin fall when clock low
// R11: Pause ends at pin rise when clock low
// R12: Paused: outputs off, inputs ignored, state kept
// R13: Host keeps chip select low while paused
// R14: Pause only without quad enable, default zero
// R15: Lane three pin: pause or reset, by select
// R16: Serial clock at most 104 MHz
// R17: Select bit one: reset pin, held 1us
// R18: Enable-reset then reset; then 30us busy
// R19: First eight bits are the instruction, MSB first
package sffe_pkg;
   localparam int CLK_MHZ   = 100;
   localparam int SCLK_MAX_MHZ = 104; // R16
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_DUAL_IO  = 8'hbb;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_QUAD_IO  = 8'heb;
   localparam logic [7:0] OP_RST_EN   = 8'h66;
   localparam logic [7:0] OP_RESET    = 8'h99;
   localparam int ADDR_BYTES = 3;
   localparam int RST_PIN_NS = 1000;
   localparam logic [6:0] RST_PIN_CYC = 7'((RST_PIN_NS * CLK_MHZ + 999) / 1000);
   localparam int SW_RST_US = 30;
   localparam logic [11:0] SW_RST_CYC = 12'(SW_RST_US * CLK_MHZ);
   // Half period 8 gives 6.25 MHz, leaving room for the device's input synchronisers
   localparam logic [3:0] HOST_HALF_CYC = 4'h8;
   localparam logic [5:0] SYNC_RST = 6'h3e;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;

   function automatic logic isRead(input logic [7:0] op);
      return op == OP_DUAL_OUT || op == OP_DUAL_IO || op == OP_QUAD_OUT || op == OP_QUAD_IO;
   endfunction

   // Data lanes of an instruction; zero means not honoured
   function automatic logic [2:0] dataLanes(input logic [7:0] op, input logic qe);
      if (op == OP_DUAL_OUT || op == OP_DUAL_IO) begin
         return 3'd2; // R6
      end else if (op == OP_QUAD_OUT || op == OP_QUAD_IO) begin
         return qe ? 3'd4 : 3'd0; // R7
      end
      return 3'd1;
   endfunction

   function automatic logic [2:0] addrLanes(input logic [7:0] op);
      if (op == OP_DUAL_IO) begin
         return 3'd2;
      end else if (op == OP_QUAD_IO) begin
         return 3'd4;
      end
      return 3'd1;
   endfunction
endpackage

// *** verif/serial_flash_spi_front_end_tb.sv ***
// Bench joining host and device ends of the flash front end
`timescale 1ns/1ns
module serial_flash_spi_front_end_tb;
   logic clk = 1'b0, rst_n = 1'b0, qe = 1'b0, pinSel = 1'b0, srProt = 1'b1, wpLevel = 1'b1, holdReq = 1'b0;
   logic rxReady = 1'b0, cmdValid = 1'b0, pausedSeen = 1'b0, busySeen = 1'b0, txSeen = 1'b0, opSeen = 1'b0;
   logic [7:0] cmdOpcode = 8'h00, cmdLen = 8'h00, wrData = 8'h00, rxData, cmdCode, rdData;
   logic [23:0] cmdAddr = 24'h000000;
   logic rxValid, txReady, opDone, swBlock, devBusy, paused, rxOverrun, cmdReady, wrReady, rdValid, hostBusy;
   logic [7:0] rdq[$];
   logic [7:0] ops[4] = '{8'h3b, 8'hbb, 8'h6b, 8'heb};
   int numErrors = 0, checks = 0;
   always #5 clk = ~clk;
   sffe_link_if u_sffe_link_if();
   sffe_device u_sffe_device(.clk, .rst_n, .link(u_sffe_link_if), .quadLaneEnableBit(qe), .pinSelBit(pinSel),
      .srProtectBit(srProt), .rxValid, .rxReady, .rxData, .txData(8'ha5), .txValid(1'b1), .txReady,
      .cmdCode, .cmdValid(opDone), .statusWriteBlock(swBlock), .busy(devBusy), .paused, .rxOverrun);
   sffe_host u_sffe_host(.clk, .rst_n, .link(u_sffe_link_if), .quadLaneEnableBit(qe), .wpLevel, .holdReq,
      .cmdValid, .cmdReady, .cmdOpcode, .cmdAddr, .cmdLen, .wrData, .wrValid(1'b1), .wrReady, .rdData,
      .rdValid, .busy(hostBusy));
   sffe_link_sva u_sffe_link_sva(.clk, .rst_n, .sclk(u_sffe_link_if.sclk), .csN(u_sffe_link_if.csN),
      .hostOut(u_sffe_link_if.hostOut), .hostOeN(u_sffe_link_if.hostOeN), .devOut(u_sffe_link_if.devOut),
      .devOeN(u_sffe_link_if.devOeN), .lane(u_sffe_link_if.lane));
   always @(posedge clk) begin
      if (wrReady) wrData <= #1 wrData + 8'h01;
      if (rdValid) rdq.push_back(rdData);
      if (paused) pausedSeen <= 1'b1;
      if (devBusy) busySeen <= 1'b1;
      if (txReady) txSeen <= 1'b1;
      if (opDone) opSeen <= 1'b1;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         numErrors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic frame(input logic [7:0] op, input logic [7:0] len);
      int k = 0;
      cmdOpcode = op;
      cmdLen = len;
      cmdValid = 1'b1;
      while (cmdReady !== 1'b1 && k < 100) begin step(1); k++; end
      check("accepted", 8'(cmdReady), 8'h01);
      cmdValid = 1'b0;
      // Busy flag lags acceptance by one cycle
      step(1);
      while (hostBusy !== 1'b0 && k < 20000) begin step(1); k++; end
      check("host idle", 8'(hostBusy), 8'h00);
   endtask
   task automatic pop(input logic [7:0] exp);
      int k = 0;
      while (rxValid !== 1'b1 && k < 50) begin step(1); k++; end
      check("rx valid", 8'(rxValid), 8'h01);
      check("rx byte", rxData, exp);
      rxReady = 1'b1;
      step(1);
      rxReady = 1'b0;
   endtask
   task automatic reads(input logic [7:0] n, input logic [7:0] exp);
      check("read count", 8'(rdq.size()), n);
      while (rdq.size() > 0) check("read data", rdq.pop_front(), exp);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, numErrors);
      if (numErrors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #800000;
      numErrors++;
      report_and_stop();
   end
   initial begin
      step(10);
      rst_n = 1'b1;
      step(2);
      // Sink stalled: seventeenth byte must be refused
      frame(8'h02, 8'd17);
      check("opcode", cmdCode, 8'h02);
      check("opcode done", 8'(opSeen), 8'h01);
      check("overrun", 8'(rxOverrun), 8'h01);
      for (int i = 0; i < 16; i++) pop(8'(i));
      check("drained", 8'(rxValid), 8'h00);
      qe = 1'b1;
      foreach (ops[i]) begin
         cmdAddr = 24'h5c3a91 + 24'(i);
         frame(ops[i], 8'd2);
         for (int b = 2; b >= 0; b--) pop(cmdAddr[8*b +: 8]);
         reads(8'd2, 8'ha5);
      end
      check("tx taken", 8'(txSeen), 8'h01);
      check("overrun cleared", 8'(rxOverrun), 8'h00);
      qe = 1'b0;
      frame(8'h6b, 8'd1);
      reads(8'd1, 8'hff);
      check("refused rx", 8'(rxValid), 8'h00);
      // Pause lands inside the address phase of a dual read
      fork
         frame(8'hbb, 8'd2);
         begin step(200); holdReq = 1'b1; step(40); holdReq = 1'b0; end
      join
      check("paused", 8'(pausedSeen), 8'h01);
      for (int b = 2; b >= 0; b--) pop(cmdAddr[8*b +: 8]);
      reads(8'd2, 8'ha5);
      wpLevel = 1'b0;
      step(6);
      check("protect", 8'(swBlock), 8'h01);
      srProt = 1'b0;
      step(6);
      check("protect bit off", 8'(swBlock), 8'h00);
      srProt = 1'b1;
      qe = 1'b1;
      step(6);
      check("protect quad", 8'(swBlock), 8'h00);
      qe = 1'b0;
      wpLevel = 1'b1;
      step(6);
      check("protect off", 8'(swBlock), 8'h00);
      busySeen = 1'b0;
      frame(8'h66, 8'd0);
      frame(8'h99, 8'd0);
      check("sw reset busy", 8'(busySeen), 8'h01);
      step(20);
      frame(8'h02, 8'd1);
      pop(8'h11);
      pinSel = 1'b1;
      busySeen = 1'b0;
      holdReq = 1'b1;
      step(150);
      check("pin reset", 8'(busySeen), 8'h01);
      holdReq = 1'b0;
      step(5);
      check("pin released", 8'(devBusy), 8'h00);
      report_and_stop();
   end
endmodule

// *** verif/sffe_link_sva.sv ***
// Link protocol checker for the serial flash front end
`timescale 1ns/1ns
module sffe_link_sva (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Link wires
   input wire logic       sclk,
   input wire logic       csN,
   input wire logic [3:0] hostOut,
   input wire logic [3:0] hostOeN,
   input wire logic [3:0] devOut,
   input wire logic [3:0] devOeN,
   input wire logic [3:0] lane
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_cs_high_quiet: assert property (csN [*8] |-> devOeN == 4'hf)
      else $error("lane driven while deselected");
   a_cs_fall_low: assert property ($fell(csN) |-> !sclk)
      else $error("clock high at select");
   a_cs_rise_low: assert property ($rose(csN) |-> !sclk)
      else $error("clock high at deselect");
   a_out_on_low: assert property (!devOeN[1] && !$past(devOeN[1]) && $changed(devOut[1]) |-> !sclk)
      else $error("output moved while clock high");
   a_in_on_low: assert property (!hostOeN[0] && $changed(hostOut[0]) |-> !sclk)
      else $error("input moved while clock high");
   // Pause only counts when the host owns lane three
   a_pause_quiet: assert property ((!csN && !sclk && !hostOeN[3] && !hostOut[3]) [*8] |-> devOeN == 4'hf)
      else $error("lanes driven while paused");
   a_no_contention: assert property ((~devOeN & ~hostOeN) == 4'h0)
      else $error("both ends drive a lane");
   a_clk_half: assert property ($changed(sclk) |=> $stable(sclk) [*7])
      else $error("link clock too fast");
   c_quad: cover property (devOeN == 4'h0);
   c_dual: cover property (devOeN == 4'hc);
   c_pause: cover property (!csN && !lane[3] && !hostOeN[3]);
   c_frame: cover property ($fell(csN));
endmodule
